// file: core/sfp_defines.svh
// Constants for the segmented flash program/erase sequencer.
// Assumes a 16-bit byte address space and an APB register port.
//
// Summary of operation
// R1: Program requests come from CPU, debug port or serial boot loader.
// R2: Each write stores exactly one byte or one 16-bit word.
// R3: Main memory is split into erase segments of 512 bytes.
// R4: Information memory has four 64-byte segments, A through D.
// R5: Erase all main segments at once, or any single main segment.
// R6: Erase each info segment alone, or all info with main together.
// R7: Segment A is locked after reset until software unlocks it.
// R8: Segment A holds oscillator range/tap calibration pairs at 010F8h-010FFh.
// R9: Requests against locked segment A leave it unchanged; a program or segment erase of it sets the violation flag.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH

// Flash geometry
`define SFP_MAIN_SEG_BYTES 512
`define SFP_MAIN_SEG_MASK 16'h01FF
`define SFP_INFO_SEGS 4
`define SFP_INFO_SEG_BYTES 64
`define SFP_INFO_SEG_MASK 16'h003F
`define SFP_INFO_BASE 16'h1000
`define SFP_INFO_LAST 16'h10FF
`define SFP_SEGA_BASE 16'h10C0
`define SFP_TOP_PLUS1 32'h0001_0000
`define SFP_ERASED 16'hFFFF

// Calibration register indices; byte address on APB is four times the index
`define SFP_IDX_OSC_TAP_CAL_16MHZ 16'h10F8
`define SFP_IDX_OSC_RANGE_CAL_16MHZ 16'h10F9
`define SFP_IDX_OSC_TAP_CAL_12MHZ 16'h10FA
`define SFP_IDX_OSC_RANGE_CAL_12MHZ 16'h10FB
`define SFP_IDX_OSC_TAP_CAL_8MHZ 16'h10FC
`define SFP_IDX_OSC_RANGE_CAL_8MHZ 16'h10FD
`define SFP_IDX_OSC_TAP_CAL_1MHZ 16'h10FE
`define SFP_IDX_OSC_RANGE_CAL_1MHZ 16'h10FF

// Control register byte offsets
`define SFP_REG_LOCK 16'h0000
`define SFP_REG_ADDR 16'h0004
`define SFP_REG_DATA 16'h0008
`define SFP_REG_CMD 16'h000C
`define SFP_REG_STATUS 16'h0010
`define SFP_REG_FLASH_RD 16'h0014

// Field positions
`define SFP_CMD_OP_MSB 2
`define SFP_CMD_SRC_LSB 4
`define SFP_CMD_SRC_MSB 5
`define SFP_ST_BUSY 0
`define SFP_ST_DONE 1
`define SFP_ST_VIOL 2
`define SFP_ST_CMDERR 3
`define SFP_ST_SRC_LSB 4
`define SFP_ST_SRC_MSB 5

// Reset values
`define SFP_LOCK_RST 1'b1

`endif

// file: core/sfp_pkg.sv
// Types shared by the flash sequencer files.
// Assumes sfp_defines.svh carries all numeric constants.
package sfp_pkg;

    typedef enum logic [2:0] {
        SFP_OP_NONE = 3'h0,
        SFP_OP_PROG_BYTE = 3'h1,
        SFP_OP_PROG_WORD = 3'h2,
        SFP_OP_ERASE_SEG = 3'h3,
        SFP_OP_ERASE_MAIN = 3'h4,
        SFP_OP_ERASE_ALL = 3'h5
    } sfp_op_type;

    typedef enum logic [1:0] {
        SFP_SRC_CPU = 2'h0,
        SFP_SRC_DEBUG = 2'h1,
        SFP_SRC_BOOT = 2'h2
    } sfp_src_type;

    typedef enum logic [1:0] {
        SFP_ST_IDLE = 2'b00,
        SFP_ST_PROG = 2'b01,
        SFP_ST_ERASE = 2'b10
    } sfp_state_type;

endpackage

// file: core/sfp_mem_if.sv
// Word port between the sequencer and the flash array.
// Assumes a single clock shared by both ends.
`timescale 1ns/10ps
interface sfp_mem_if #(parameter int IW = 13);
    logic en;
    logic we;
    logic [1:0] be;
    logic [IW-1:0] idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport ctrl (output en, output we, output be, output idx, output wdata, input rdata);
    modport mem (input en, input we, input be, input idx, input wdata, output rdata);
endinterface

// file: core/sfp_flash_array.sv
// Flash word array with byte lanes and registered read data.
// Assumes indices from the controller always fall inside the array.
`timescale 1ns/10ps
`include "sfp_defines.svh"
module sfp_flash_array #(
    parameter int WORDS = 4224,
    parameter int IW = 13,
    parameter logic [63:0] CAL_INIT = 64'hFFFF_FFFF_FFFF_FFFF
) (
    // Clock
    input wire logic clk,
    // Word port
    sfp_mem_if.mem mp
);
    localparam int CAL_WORD = (`SFP_IDX_OSC_TAP_CAL_16MHZ - `SFP_INFO_BASE) / 2;

    logic [15:0] mem [WORDS];
    logic [15:0] rdata_r;

    // Factory image: blank array, calibration pairs in segment A
    initial begin
        for (int i = 0; i < WORDS; i++) begin
            mem[i] = `SFP_ERASED;
        end
        for (int k = 0; k < 4; k++) begin
            mem[CAL_WORD + k] = CAL_INIT[16*k +: 16]; // R8
        end
    end

    always_ff @(posedge clk) begin
        if (mp.en && mp.we) begin
            if (mp.be[0]) begin
                mem[mp.idx][7:0] <= mp.wdata[7:0];
            end
            if (mp.be[1]) begin
                mem[mp.idx][15:8] <= mp.wdata[15:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (mp.en && !mp.we) begin
            rdata_r <= mem[mp.idx];
        end
    end

    assign mp.rdata = rdata_r;
endmodule // sfp_flash_array

// file: core/sfp_flash_ctrl.sv
// Flash program/erase sequencer with APB registers and an external request port.
// Assumes debug and boot loader requesters run on pclk.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "sfp_defines.svh"
module sfp_flash_ctrl #(
    parameter int MAIN_SEGS = 16,
    parameter logic [63:0] CAL_INIT = 64'hFFFF_FFFF_FFFF_FFFF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Debug port / boot loader requests
    input wire logic ext_req_valid,
    input wire logic [1:0] ext_req_src,
    input wire logic [2:0] ext_req_op,
    input wire logic [15:0] ext_req_addr,
    input wire logic [15:0] ext_req_data,
    output logic ext_req_ready,
    // Status
    output logic flash_busy
);
    localparam int INFO_WORDS = `SFP_INFO_SEGS * `SFP_INFO_SEG_BYTES / 2;
    localparam int WORDS = INFO_WORDS + MAIN_SEGS * `SFP_MAIN_SEG_BYTES / 2;
    localparam int IW = $clog2(WORDS);
    localparam logic [16:0] MAIN_BASE = 17'(`SFP_TOP_PLUS1 - MAIN_SEGS * `SFP_MAIN_SEG_BYTES);
    localparam logic [IW-1:0] SEGA_FIRST = IW'((`SFP_SEGA_BASE - `SFP_INFO_BASE) / 2);
    localparam logic [IW-1:0] SEGA_LAST = IW'(INFO_WORDS - 1);
    localparam logic [IW-1:0] INFO_SEG_LEN = IW'(`SFP_INFO_SEG_BYTES / 2 - 1);
    localparam logic [IW-1:0] MAIN_SEG_LEN = IW'(`SFP_MAIN_SEG_BYTES / 2 - 1);

    sfp_mem_if #(.IW(IW)) mbus ();

    sfp_flash_array #(.WORDS(WORDS), .IW(IW), .CAL_INIT(CAL_INIT)) u_array (
        .clk(pclk),
        .mp(mbus.mem)
    );

    function automatic logic is_info(input logic [15:0] a);
        return (a >= `SFP_INFO_BASE) && (a <= `SFP_INFO_LAST);
    endfunction

    function automatic logic is_main(input logic [15:0] a);
        return {1'b0, a} >= MAIN_BASE;
    endfunction

    // Byte address to word index: info words first, main words after
    function automatic logic [IW-1:0] word_idx(input logic [15:0] a);
        logic [15:0] off;
        off = is_info(a) ? (a - `SFP_INFO_BASE) : (a - MAIN_BASE[15:0]);
        return is_info(a) ? IW'(off >> 1) : IW'(INFO_WORDS + 32'(off >> 1));
    endfunction

    function automatic logic in_seg_a(input logic [IW-1:0] i);
        return (i >= SEGA_FIRST) && (i <= SEGA_LAST);
    endfunction

    // Registers
    sfp_pkg::sfp_state_type state_r;
    sfp_pkg::sfp_op_type op_r;
    sfp_pkg::sfp_src_type src_r;
    logic lock_a_r;
    logic [15:0] addr_r;
    logic [15:0] data_r;
    logic [15:0] op_addr_r;
    logic [15:0] op_data_r;
    logic [IW-1:0] idx_r;
    logic [IW-1:0] last_r;
    logic done_r;
    logic viol_r;
    logic cmderr_r;
    logic ready_r;
    logic issued_r;
    logic slverr_r;
    logic [31:0] prdata_r;

    // Request selection
    logic apb_acc;
    logic apb_wr_now;
    logic cmd_wr;
    logic start;
    sfp_pkg::sfp_op_type req_op;
    sfp_pkg::sfp_src_type req_src;
    logic [15:0] req_addr;
    logic [15:0] req_data;

    assign apb_acc = psel && penable;
    assign apb_wr_now = apb_acc && pwrite && ready_r && !slverr_r;
    assign cmd_wr = apb_wr_now && (paddr == `SFP_REG_CMD);
    assign ext_req_ready = (state_r == sfp_pkg::SFP_ST_IDLE) && !cmd_wr; // R1
    assign start = (cmd_wr && state_r == sfp_pkg::SFP_ST_IDLE)
        || (ext_req_valid && ext_req_ready); // R1

    always_comb begin
        if (cmd_wr) begin
            req_op = sfp_pkg::sfp_op_type'(pwdata[`SFP_CMD_OP_MSB:0]);
            req_src = sfp_pkg::sfp_src_type'(pwdata[`SFP_CMD_SRC_MSB:`SFP_CMD_SRC_LSB]);
            req_addr = addr_r;
            req_data = data_r;
        end else begin
            req_op = sfp_pkg::sfp_op_type'(ext_req_op);
            req_src = sfp_pkg::sfp_src_type'(ext_req_src);
            req_addr = ext_req_addr;
            req_data = ext_req_data;
        end
    end

    // Request decode: range, lock and erase span
    logic go_prog;
    logic go_erase;
    logic bad_target;
    logic bad_code;
    logic [IW-1:0] first_idx;
    logic [IW-1:0] last_idx;
    logic [IW-1:0] tgt_idx;

    always_comb begin
        go_prog = 1'b0;
        go_erase = 1'b0;
        bad_target = 1'b0;
        bad_code = 1'b0;
        first_idx = '0;
        last_idx = '0;
        tgt_idx = word_idx(req_addr);
        case (req_op)
            sfp_pkg::SFP_OP_PROG_BYTE, sfp_pkg::SFP_OP_PROG_WORD: begin // R2
                if (!(is_info(req_addr) || is_main(req_addr))) begin
                    bad_target = 1'b1;
                end else if (lock_a_r && in_seg_a(tgt_idx)) begin
                    bad_target = 1'b1; // R7 R9
                end else begin
                    go_prog = 1'b1;
                end
            end
            sfp_pkg::SFP_OP_ERASE_SEG: begin
                if (is_info(req_addr)) begin
                    first_idx = word_idx(req_addr & ~`SFP_INFO_SEG_MASK); // R4 R6
                    last_idx = first_idx + INFO_SEG_LEN;
                end else begin
                    first_idx = word_idx(req_addr & ~`SFP_MAIN_SEG_MASK); // R3 R5
                    last_idx = first_idx + MAIN_SEG_LEN;
                end
                if (!(is_info(req_addr) || is_main(req_addr))) begin
                    bad_target = 1'b1;
                end else if (lock_a_r && in_seg_a(first_idx)) begin
                    bad_target = 1'b1; // R7 R9
                end else begin
                    go_erase = 1'b1;
                end
            end
            sfp_pkg::SFP_OP_ERASE_MAIN: begin
                first_idx = IW'(INFO_WORDS); // R5
                last_idx = IW'(WORDS - 1);
                go_erase = 1'b1;
            end
            sfp_pkg::SFP_OP_ERASE_ALL: begin
                first_idx = '0; // R6
                last_idx = IW'(WORDS - 1);
                go_erase = 1'b1;
            end
            default: begin
                bad_code = 1'b1;
            end
        endcase
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sfp_pkg::SFP_ST_IDLE;
            op_r <= sfp_pkg::SFP_OP_NONE;
            src_r <= sfp_pkg::SFP_SRC_CPU;
            op_addr_r <= '0;
            op_data_r <= '0;
            idx_r <= '0;
            last_r <= '0;
        end else begin
            unique case (state_r)
                sfp_pkg::SFP_ST_IDLE: begin
                    if (start && !bad_code) begin
                        op_r <= req_op;
                        src_r <= req_src; // R1
                        op_addr_r <= req_addr;
                        op_data_r <= req_data;
                        idx_r <= first_idx;
                        last_r <= last_idx;
                        if (go_prog) begin
                            state_r <= sfp_pkg::SFP_ST_PROG;
                        end else if (go_erase) begin
                            state_r <= sfp_pkg::SFP_ST_ERASE;
                        end
                    end
                end
                sfp_pkg::SFP_ST_PROG: begin
                    state_r <= sfp_pkg::SFP_ST_IDLE; // R2
                end
                sfp_pkg::SFP_ST_ERASE: begin
                    if (idx_r == last_r) begin
                        state_r <= sfp_pkg::SFP_ST_IDLE;
                    end else begin
                        idx_r <= idx_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // APB register selection
    logic cal_sel;
    logic mem_reg;
    logic mem_issue;
    logic [15:0] rd_addr;
    logic reg_hit;
    logic [31:0] reg_rd;

    assign cal_sel = (paddr[1:0] == 2'b00)
        && (paddr[15:2] >= 14'(`SFP_IDX_OSC_TAP_CAL_16MHZ))
        && (paddr[15:2] <= 14'(`SFP_IDX_OSC_RANGE_CAL_1MHZ)); // R8
    assign mem_reg = cal_sel || (paddr == `SFP_REG_FLASH_RD);
    assign rd_addr = cal_sel ? {2'b00, paddr[15:2]} : {addr_r[15:1], 1'b0};
    assign mem_issue = apb_acc && !pwrite && mem_reg && !ready_r && !issued_r
        && (state_r == sfp_pkg::SFP_ST_IDLE);

    always_comb begin
        reg_hit = 1'b1;
        reg_rd = '0;
        unique case (paddr)
            `SFP_REG_LOCK: reg_rd[0] = lock_a_r;
            `SFP_REG_ADDR: reg_rd[15:0] = addr_r;
            `SFP_REG_DATA: reg_rd[15:0] = data_r;
            `SFP_REG_CMD: reg_rd = 32'({src_r, 1'b0, op_r});
            `SFP_REG_STATUS: begin
                reg_rd[`SFP_ST_BUSY] = state_r != sfp_pkg::SFP_ST_IDLE;
                reg_rd[`SFP_ST_DONE] = done_r;
                reg_rd[`SFP_ST_VIOL] = viol_r;
                reg_rd[`SFP_ST_CMDERR] = cmderr_r;
                reg_rd[`SFP_ST_SRC_MSB:`SFP_ST_SRC_LSB] = src_r;
            end
            default: reg_hit = 1'b0;
        endcase
    end

    // APB handshake: registered ready, one wait cycle, one more for flash reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r <= 1'b0;
            issued_r <= 1'b0;
            slverr_r <= 1'b0;
            prdata_r <= '0;
        end else if (ready_r) begin
            ready_r <= 1'b0;
            issued_r <= 1'b0;
            slverr_r <= 1'b0;
        end else if (apb_acc) begin
            if (mem_reg && !pwrite) begin
                if (issued_r) begin
                    prdata_r <= (cal_sel && paddr[2])
                        ? {24'h0, mbus.rdata[15:8]}
                        : (cal_sel ? {24'h0, mbus.rdata[7:0]} : {16'h0, mbus.rdata});
                    ready_r <= 1'b1;
                end else if (mem_issue) begin
                    issued_r <= 1'b1;
                end
            end else begin
                prdata_r <= (pwrite || !reg_hit) ? '0 : reg_rd;
                slverr_r <= mem_reg || !reg_hit;
                ready_r <= 1'b1;
            end
        end
    end

    // Software registers, written at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_a_r <= `SFP_LOCK_RST; // R7
            addr_r <= '0;
            data_r <= '0;
        end else if (apb_wr_now) begin
            if (paddr == `SFP_REG_LOCK) begin
                lock_a_r <= pwdata[0]; // R7
            end
            if (paddr == `SFP_REG_ADDR) begin
                addr_r <= pwdata[15:0];
            end
            if (paddr == `SFP_REG_DATA) begin
                data_r <= pwdata[15:0];
            end
        end
    end

    // Sticky status: set wins over write-one-to-clear
    logic st_clr;
    logic done_set;
    logic viol_set;
    logic cmderr_set;

    assign st_clr = apb_wr_now && (paddr == `SFP_REG_STATUS);
    assign done_set = (state_r == sfp_pkg::SFP_ST_PROG)
        || (state_r == sfp_pkg::SFP_ST_ERASE && idx_r == last_r)
        || (start && !bad_code && bad_target);
    assign viol_set = start && !bad_code && bad_target; // R9
    assign cmderr_set = (cmd_wr && state_r != sfp_pkg::SFP_ST_IDLE) || (start && bad_code);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            viol_r <= 1'b0;
            cmderr_r <= 1'b0;
        end else begin
            done_r <= done_set || (done_r && !(st_clr && pwdata[`SFP_ST_DONE]));
            viol_r <= viol_set || (viol_r && !(st_clr && pwdata[`SFP_ST_VIOL]));
            cmderr_r <= cmderr_set || (cmderr_r && !(st_clr && pwdata[`SFP_ST_CMDERR]));
        end
    end

    // Flash port
    logic word_op;
    assign word_op = op_r == sfp_pkg::SFP_OP_PROG_WORD;

    always_comb begin
        mbus.en = 1'b0;
        mbus.we = 1'b0;
        mbus.be = 2'b00;
        mbus.idx = word_idx(rd_addr);
        mbus.wdata = `SFP_ERASED;
        unique case (state_r)
            sfp_pkg::SFP_ST_IDLE: begin
                mbus.en = mem_issue;
            end
            sfp_pkg::SFP_ST_PROG: begin
                mbus.en = 1'b1; // R2
                mbus.we = 1'b1;
                mbus.idx = word_idx(op_addr_r);
                mbus.be = word_op ? 2'b11 : (op_addr_r[0] ? 2'b10 : 2'b01);
                mbus.wdata = word_op ? op_data_r : {op_data_r[7:0], op_data_r[7:0]};
            end
            sfp_pkg::SFP_ST_ERASE: begin
                mbus.en = !(lock_a_r && in_seg_a(idx_r)); // R7 R9
                mbus.we = 1'b1;
                mbus.be = 2'b11;
                mbus.idx = idx_r;
            end
        endcase
    end

    assign prdata = prdata_r;
    assign pready = ready_r;
    assign pslverr = slverr_r && ready_r;
    assign flash_busy = state_r != sfp_pkg::SFP_ST_IDLE;
endmodule // sfp_flash_ctrl

// file: tb/sfp_flash_ctrl_chk.sv
// Port checker for the flash sequencer: APB answers and the external request port.
// Assumes it is bound onto sfp_flash_ctrl, which hands on MAIN_SEGS.
`timescale 1ns/10ps
`include "sfp_defines.svh"
module sfp_flash_ctrl_chk #(
    parameter int MAIN_SEGS = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Request port and status
    input wire logic ext_req_valid,
    input wire logic [2:0] ext_req_op,
    input wire logic [15:0] ext_req_addr,
    input wire logic ext_req_ready,
    input wire logic flash_busy
);
    localparam logic [16:0] MAIN_BASE = 17'h10000 - 17'(MAIN_SEGS * 512);
    logic taken;
    logic cmd_wr;
    logic main_hit;
    logic info_hit;
    assign taken = ext_req_valid && ext_req_ready;
    assign cmd_wr = psel && penable && pwrite && pready && paddr == `SFP_REG_CMD;
    assign main_hit = {1'b0, ext_req_addr} >= MAIN_BASE;
    assign info_hit = ext_req_addr >= `SFP_INFO_BASE && ext_req_addr < `SFP_SEGA_BASE;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // One byte or word written, then idle again
    sequence s_prog_pulse;
        flash_busy ##1 !flash_busy;
    endsequence
    // One cycle per erased word: 256 for a main segment
    sequence s_main_erase;
        flash_busy [*8] ##248 flash_busy ##1 !flash_busy;
    endsequence
    // 32 words for an information segment
    sequence s_info_erase;
        flash_busy [*8] ##24 flash_busy ##1 !flash_busy;
    endsequence
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    a_busy_blocks_req: assert property (flash_busy |-> !ext_req_ready)
        else $error("request port ready while busy");
    a_idle_takes_req: assert property (!flash_busy && !cmd_wr |-> ext_req_ready)
        else $error("request port not ready while idle");
    a_busy_has_cause: assert property ($rose(flash_busy) |->
        $past(taken || cmd_wr) || $past(cmd_wr, 2))
        else $error("busy without a request");
    a_prog_one_unit: assert property (taken && main_hit &&
        (ext_req_op == sfp_pkg::SFP_OP_PROG_BYTE || ext_req_op == sfp_pkg::SFP_OP_PROG_WORD)
        |=> s_prog_pulse)
        else $error("program not a single busy cycle");
    a_main_seg_len: assert property (taken && main_hit &&
        ext_req_op == sfp_pkg::SFP_OP_ERASE_SEG |=> s_main_erase)
        else $error("main segment erase length wrong");
    a_info_seg_len: assert property (taken && info_hit &&
        ext_req_op == sfp_pkg::SFP_OP_ERASE_SEG |=> s_info_erase)
        else $error("info segment erase length wrong");
endmodule // sfp_flash_ctrl_chk

bind sfp_flash_ctrl sfp_flash_ctrl_chk #(.MAIN_SEGS(MAIN_SEGS)) u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ext_req_valid(ext_req_valid),
    .ext_req_op(ext_req_op),
    .ext_req_addr(ext_req_addr),
    .ext_req_ready(ext_req_ready),
    .flash_busy(flash_busy)
);

// file: tb/sfp_req_model.sv
// Requester model for the external port: debug port or boot loader.
// Assumes the bench launches each request with a one-cycle go pulse.
`timescale 1ns/10ps
module sfp_req_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench side
    input wire logic go,
    input wire logic [1:0] src,
    input wire logic [2:0] op,
    input wire logic [15:0] addr,
    input wire logic [15:0] data,
    // Request port
    output logic ext_req_valid,
    output logic [1:0] ext_req_src,
    output logic [2:0] ext_req_op,
    output logic [15:0] ext_req_addr,
    output logic [15:0] ext_req_data,
    input wire logic ext_req_ready
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_req_valid <= 1'b0;
            ext_req_src <= 2'h0;
            ext_req_op <= 3'h0;
            ext_req_addr <= 16'h0;
            ext_req_data <= 16'h0;
        end else if (ext_req_valid && ext_req_ready) begin
            // Released address and data fields stop showing the last request
            ext_req_valid <= 1'b0;
            ext_req_addr <= ~ext_req_addr;
            ext_req_data <= ~ext_req_data;
        end else if (go) begin
            ext_req_valid <= 1'b1;
            ext_req_src <= src;
            ext_req_op <= op;
            ext_req_addr <= addr;
            ext_req_data <= data;
        end
    end
endmodule // sfp_req_model

// file: tb/segmented_flash_program_erase_test.sv
// Directed bench for the flash sequencer: APB register tasks plus a requester model.
// Assumes MAIN_SEGS of 2, so main flash spans FC00h-FFFFh.
`timescale 1ns/10ps
`include "sfp_defines.svh"
module segmented_flash_program_erase_test;
    localparam logic [63:0] CAL = 64'h1E2D_3C4B_5A69_7887;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_busy;
    logic ext_req_valid, ext_req_ready, go, err;
    logic [1:0] ext_req_src, m_src;
    logic [2:0] ext_req_op, m_op;
    logic [15:0] paddr, ext_req_addr, ext_req_data, m_addr, m_data;
    logic [31:0] pwdata, prdata, rd;
    int failures, check_count;
    sfp_flash_ctrl #(.MAIN_SEGS(2), .CAL_INIT(CAL)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_req_valid(ext_req_valid),
        .ext_req_src(ext_req_src), .ext_req_op(ext_req_op), .ext_req_addr(ext_req_addr),
        .ext_req_data(ext_req_data), .ext_req_ready(ext_req_ready), .flash_busy(flash_busy));
    sfp_req_model u_req (.pclk(pclk), .presetn(presetn), .go(go), .src(m_src), .op(m_op),
        .addr(m_addr), .data(m_data), .ext_req_valid(ext_req_valid),
        .ext_req_src(ext_req_src), .ext_req_op(ext_req_op), .ext_req_addr(ext_req_addr),
        .ext_req_data(ext_req_data), .ext_req_ready(ext_req_ready));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait on a settled signal, sampled mid-cycle
    task automatic wait_for(input int which);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (n < 2000 && (which == 0 ? pready !== 1'b1 :
            which == 1 ? flash_busy !== 1'b0 : ext_req_valid !== 1'b0));
        if (n >= 2000) begin
            failures++;
            final_report();
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_for(0);
        @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic idle;
        repeat (2) @(negedge pclk);
        wait_for(1);
        @(posedge pclk);
    endtask
    task automatic cmd(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d);
        apb(1'b1, `SFP_REG_ADDR, {16'h0, a});
        apb(1'b1, `SFP_REG_DATA, {16'h0, d});
        apb(1'b1, `SFP_REG_CMD, {29'h0, op});
        idle();
    endtask
    task automatic ext(input logic [1:0] s, input logic [2:0] op, input logic [15:0] a,
        input logic [15:0] d);
        m_src <= s;
        m_op <= op;
        m_addr <= a;
        m_data <= d;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        wait_for(2);
        idle();
    endtask
    task automatic fread(input logic [15:0] a, input logic [15:0] exp);
        apb(1'b1, `SFP_REG_ADDR, {16'h0, a});
        apb(1'b0, `SFP_REG_FLASH_RD, 32'h0);
        chk(rd, {16'h0, exp});
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, go} = 4'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        {m_src, m_op, m_addr, m_data} = 37'h0;
        failures = 0;
        check_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `SFP_REG_LOCK, 32'h0);
        chk(rd, 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 16'(4 * (`SFP_IDX_OSC_TAP_CAL_16MHZ + i)), 32'h0);
            chk(rd, {24'h0, CAL[8*i +: 8]});
        end
        apb(1'b1, 16'h43E0, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset_cal done");
        cmd(3'h2, 16'hFC10, 16'hA55A);
        fread(16'hFC10, 16'hA55A);
        cmd(3'h1, 16'hFC11, 16'h773C);
        fread(16'hFC10, 16'h3C5A);
        ext(2'h1, 3'h2, 16'hFC20, 16'h1234);
        ext(2'h2, 3'h1, 16'hFC21, 16'h0056);
        fread(16'hFC20, 16'h5634);
        apb(1'b0, `SFP_REG_STATUS, 32'h0);
        chk({30'h0, rd[5:4]}, 32'h2);
        $display("test program done");
        cmd(3'h2, 16'hFDFE, 16'hBEEF);
        cmd(3'h2, 16'hFE00, 16'hCAFE);
        ext(2'h2, 3'h3, 16'hFC00, 16'h0);
        fread(16'hFC10, 16'hFFFF);
        fread(16'hFDFE, 16'hFFFF);
        fread(16'hFE00, 16'hCAFE);
        ext(2'h1, 3'h4, 16'hFE00, 16'h0);
        fread(16'hFE00, 16'hFFFF);
        $display("test main_erase done");
        cmd(3'h2, 16'h1080, 16'h0B0B);
        cmd(3'h2, 16'h10BE, 16'h0B0C);
        cmd(3'h2, 16'h1040, 16'h0C0C);
        cmd(3'h2, 16'h10F8, 16'h0000);
        apb(1'b0, `SFP_REG_STATUS, 32'h0);
        chk({31'h0, rd[2]}, 32'h1);
        fread(16'h10F8, CAL[15:0]);
        ext(2'h1, 3'h3, 16'h1080, 16'h0);
        fread(16'h1080, 16'hFFFF);
        fread(16'h10BE, 16'hFFFF);
        fread(16'h1040, 16'h0C0C);
        cmd(3'h3, 16'h10C0, 16'h0);
        fread(16'h10FE, CAL[63:48]);
        cmd(3'h5, 16'hFC00, 16'h0);
        fread(16'h1040, 16'hFFFF);
        fread(16'h10FA, CAL[31:16]);
        apb(1'b1, `SFP_REG_LOCK, 32'h0);
        cmd(3'h2, 16'h10F8, 16'h5AA5);
        fread(16'h10F8, 16'h5AA5);
        $display("test info_lock done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `SFP_REG_LOCK, 32'h0);
        chk(rd, 32'h1);
        fread(16'h10F8, 16'h5AA5);
        $display("test second_reset done");
        final_report();
    end
endmodule // segmented_flash_program_erase_test
